// >>> inc/ctrl_load_pkg.sv
package ctrl_load_pkg;

   // ------------------------------------------------------------------
   // values and timing
   // ------------------------------------------------------------------
   localparam logic [31:0] STATUS_MASK   = 32'h0fff0fff;
   localparam logic [31:0] CREG_RESET    = 32'h0000_0000;
   localparam logic [31:0] PC_AHEAD      = 32'h0000_0004;
   localparam logic [31:0] SLOT_PC_OFS   = 32'h0000_0002;
   localparam logic [31:0] GPR_POSTINC   = 32'h0000_0004;
   localparam int          MEM_CYCLES    = 3;

   // ------------------------------------------------------------------
   // opcode fields
   // ------------------------------------------------------------------
   localparam int          SRC_LSB       = 8;
   localparam int          SRC_MSB       = 11;
   localparam int          DISP_MSB      = 7;
   localparam logic [3:0]  GRP_CTRL      = 4'h4;
   localparam logic [3:0]  NIB_CTL_REG   = 4'he;
   localparam logic [3:0]  NIB_CTL_MEM   = 4'h7;
   localparam logic [3:0]  CSEL_STATUS   = 4'h0;
   localparam logic [3:0]  CSEL_GPTR     = 4'h1;
   localparam logic [3:0]  CSEL_VTAB     = 4'h2;
   localparam logic [3:0]  CSEL_WRAP     = 4'h5;
   localparam logic [3:0]  CSEL_LBEG     = 4'h6;
   localparam logic [3:0]  CSEL_LEND     = 4'h7;
   localparam logic [15:0] MASK_SRC      = 16'hf0ff;
   localparam logic [15:0] MASK_HI8      = 16'hff00;
   localparam logic [15:0] MASK_HI4      = 16'hf000;
   localparam logic [15:0] OPC_CALL      = 16'h400b;
   localparam logic [15:0] OPC_JUMP      = 16'h402b;
   localparam logic [15:0] OPC_LOOP_END  = 16'h8e00;
   localparam logic [15:0] OPC_LOOP_BEG  = 16'h8c00;
   localparam logic [15:0] OPC_BRA       = 16'ha000;
   localparam logic [15:0] OPC_BSR       = 16'hb000;
   localparam logic [15:0] OPC_BT        = 16'h8900;
   localparam logic [15:0] OPC_BF        = 16'h8b00;
   localparam logic [15:0] OPC_BTS       = 16'h8d00;
   localparam logic [15:0] OPC_BFS       = 16'h8f00;
   localparam logic [15:0] OPC_RTS       = 16'h000b;
   localparam logic [15:0] OPC_RTE       = 16'h002b;
   localparam logic [15:0] OPC_BRAF      = 16'h0023;
   localparam logic [15:0] OPC_BSRF      = 16'h0003;

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_NONE, OP_CTL_REG, OP_CTL_MEM, OP_LOOP_END, OP_LOOP_BEGIN, OP_DBRANCH, OP_BRANCH, OP_ILLEGAL
   } op_t;

   typedef enum logic [2:0] {CR_STATUS, CR_GPTR, CR_VTAB, CR_WRAP, CR_LEND, CR_LBEG} creg_t;

   typedef enum logic [2:0] {
      ST_EXEC  = 3'b001,
      ST_MEMRD = 3'b010,
      ST_MEMWB = 3'b100
   } state_t;

   // sign-extended displacement, doubled
   function automatic logic [31:0] disp_offset(input logic [7:0] d);
      return {{23{d[7]}}, d, 1'b0};
   endfunction

endpackage

// >>> inc/dec_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dec_if;
   import ctrl_load_pkg::*;
   logic [15:0] insn;
   op_t         op;
   creg_t       creg;
   logic        link;
   modport dec  (input insn, output op, creg, link);
   modport core (output insn, input op, creg, link);
endinterface // dec_if
`default_nettype wire

// >>> verilog/insn_decode.sv
`timescale 1ns/1ns
`default_nettype none
module insn_decode
   import ctrl_load_pkg::*;
#(
   parameter bit HAS_REPEAT = 1'b1
) (
   dec_if.dec d
);

   // ------------------------------------------------------------------
   // opcode classification
   // ------------------------------------------------------------------
   function automatic logic is_branch(input logic [15:0] i);
      return ((i & MASK_SRC) == OPC_CALL) || ((i & MASK_SRC) == OPC_JUMP) ||
             ((i & MASK_HI4) == OPC_BRA) || ((i & MASK_HI4) == OPC_BSR) ||
             ((i & MASK_HI8) == OPC_BT)  || ((i & MASK_HI8) == OPC_BF)  ||
             ((i & MASK_HI8) == OPC_BTS) || ((i & MASK_HI8) == OPC_BFS) ||
             (i == OPC_RTS) || (i == OPC_RTE) ||
             ((i & MASK_SRC) == OPC_BRAF) || ((i & MASK_SRC) == OPC_BSRF);
   endfunction

   always_comb begin
      d.op   = OP_NONE;
      d.creg = CR_STATUS;
      d.link = 1'b0;
      if (d.insn[15:12] == GRP_CTRL && (d.insn[3:0] == NIB_CTL_REG || d.insn[3:0] == NIB_CTL_MEM)) begin
         d.op = (d.insn[3:0] == NIB_CTL_MEM) ? OP_CTL_MEM : OP_CTL_REG;
         case (d.insn[7:4])
            CSEL_STATUS: d.creg = CR_STATUS;
            CSEL_GPTR:   d.creg = CR_GPTR;
            CSEL_VTAB:   d.creg = CR_VTAB;
            CSEL_WRAP:   d.creg = CR_WRAP;
            CSEL_LEND:   d.creg = CR_LEND;
            CSEL_LBEG:   d.creg = CR_LBEG;
            default:     d.op   = OP_NONE;
         endcase
      end else if ((d.insn & MASK_HI8) == OPC_LOOP_END) begin
         d.op = HAS_REPEAT ? OP_LOOP_END : OP_ILLEGAL;
      end else if ((d.insn & MASK_HI8) == OPC_LOOP_BEG) begin
         d.op = HAS_REPEAT ? OP_LOOP_BEGIN : OP_ILLEGAL;
      end else if ((d.insn & MASK_SRC) == OPC_CALL || (d.insn & MASK_SRC) == OPC_JUMP) begin
         d.op   = OP_DBRANCH;
         d.link = ((d.insn & MASK_SRC) == OPC_CALL);
      end else if (is_branch(d.insn)) begin
         d.op = OP_BRANCH;
      end
   end

endmodule // insn_decode
`default_nettype wire

// >>> verilog/ctrl_load_unit.sv
`timescale 1ns/1ns
`default_nettype none
module ctrl_load_unit
   import ctrl_load_pkg::*;
#(
   parameter bit HAS_REPEAT = 1'b1
) (
   input  wire  logic        ref_clk,
   input  wire  logic        rst,
   input  wire  logic        clk_en,
   input  wire  logic        insn_valid,
   input  wire  logic [15:0] insn,
   input  wire  logic [31:0] insn_addr,
   input  wire  logic [31:0] src_gpr,
   input  wire  logic        mem_rd_valid,
   input  wire  logic [31:0] mem_rd_data,
   output var   logic        insn_ready_q,
   output var   logic [31:0] status_word_q,
   output var   logic [31:0] global_base_ptr_q,
   output var   logic [31:0] vector_table_base_q,
   output var   logic [31:0] address_wrap_bounds_q,
   output var   logic [31:0] loop_end_addr_q,
   output var   logic [31:0] loop_begin_addr_q,
   output var   logic        gpr_wr_en_q,
   output var   logic [3:0]  gpr_wr_idx_q,
   output var   logic [31:0] gpr_wr_data_q,
   output var   logic        link_wr_en_q,
   output var   logic [31:0] link_wr_data_q,
   output var   logic        mem_rd_req_q,
   output var   logic [31:0] mem_rd_addr_q,
   output var   logic        redirect_q,
   output var   logic [31:0] redirect_addr_q,
   output var   logic        illegal_slot_q,
   output var   logic        illegal_insn_q,
   output var   logic        irq_block_q
);

   // ------------------------------------------------------------------
   // decode
   // ------------------------------------------------------------------
   dec_if dv ();
   assign dv.insn = insn;

   insn_decode #(.HAS_REPEAT(HAS_REPEAT)) u_dec (.d(dv.dec));

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   state_t      state_q, state_d;
   logic        pend_q, pend_d;
   logic [31:0] tgt_q, tgt_d;
   logic [31:0] base_q, base_d;
   logic [31:0] data_q, data_d;
   creg_t       csel_q, csel_d;
   logic        ready_d;
   logic [31:0] status_d, gptr_d, vtab_d, wrap_d, lend_d, lbeg_d;
   logic        gpr_wr_en_d, link_wr_en_d, mem_rd_req_d, redirect_d;
   logic        illegal_slot_d, illegal_insn_d, irq_block_d;
   logic [3:0]  gpr_wr_idx_d;
   logic [31:0] gpr_wr_data_d, link_wr_data_d, mem_rd_addr_d, redirect_addr_d;
   logic        take, slot_done, cw_en;
   creg_t       cw_sel;
   logic [31:0] cw_val, pc_base;

   assign take = insn_valid & insn_ready_q;

   always_comb begin
      state_d         = state_q;
      ready_d         = insn_ready_q;
      pend_d          = pend_q;
      tgt_d           = tgt_q;
      base_d          = base_q;
      data_d          = data_q;
      csel_d          = csel_q;
      status_d        = status_word_q;
      gptr_d          = global_base_ptr_q;
      vtab_d          = vector_table_base_q;
      wrap_d          = address_wrap_bounds_q;
      lend_d          = loop_end_addr_q;
      lbeg_d          = loop_begin_addr_q;
      gpr_wr_en_d     = 1'b0;
      gpr_wr_idx_d    = gpr_wr_idx_q;
      gpr_wr_data_d   = gpr_wr_data_q;
      link_wr_en_d    = 1'b0;
      link_wr_data_d  = link_wr_data_q;
      mem_rd_req_d    = 1'b0;
      mem_rd_addr_d   = mem_rd_addr_q;
      redirect_d      = 1'b0;
      redirect_addr_d = redirect_addr_q;
      illegal_slot_d  = 1'b0;
      illegal_insn_d  = 1'b0;
      irq_block_d     = irq_block_q;
      slot_done       = 1'b0;
      cw_en           = 1'b0;
      cw_sel          = CR_STATUS;
      cw_val          = src_gpr;
      // slot instructions see the branch target plus two as PC
      pc_base = pend_q ? tgt_q + SLOT_PC_OFS : insn_addr + PC_AHEAD;
      unique case (state_q)
         ST_EXEC: begin
            if (take) begin
               irq_block_d = 1'b0;
               slot_done   = pend_q;
               case (dv.op)
                  OP_CTL_REG: begin
                     cw_en       = 1'b1;
                     cw_sel      = dv.creg;
                     irq_block_d = 1'b1;
                  end
                  OP_CTL_MEM: begin
                     mem_rd_req_d  = 1'b1;
                     mem_rd_addr_d = src_gpr;
                     base_d        = src_gpr;
                     gpr_wr_idx_d  = insn[SRC_MSB:SRC_LSB];
                     csel_d        = dv.creg;
                     state_d       = ST_MEMRD;
                     ready_d       = 1'b0;
                     irq_block_d   = pend_q;
                     slot_done     = 1'b0;
                  end
                  OP_LOOP_END: begin
                     lend_d = pc_base + disp_offset(insn[DISP_MSB:0]);
                  end
                  OP_LOOP_BEGIN: begin
                     lbeg_d = pc_base + disp_offset(insn[DISP_MSB:0]);
                  end
                  OP_DBRANCH: begin
                     if (!pend_q) begin
                        pend_d         = 1'b1;
                        tgt_d          = src_gpr;
                        irq_block_d    = 1'b1;
                        link_wr_en_d   = dv.link;
                        link_wr_data_d = insn_addr + PC_AHEAD;
                     end
                  end
                  OP_ILLEGAL: begin
                     illegal_insn_d = 1'b1;
                     pend_d         = 1'b0;
                     slot_done      = 1'b0;
                  end
                  default: begin
                  end
               endcase
               if (pend_q && (dv.op == OP_DBRANCH || dv.op == OP_BRANCH)) begin
                  illegal_slot_d = 1'b1;
                  pend_d         = 1'b0;
                  slot_done      = 1'b0;
               end
            end
         end
         ST_MEMRD: begin
            if (mem_rd_valid) begin
               data_d  = mem_rd_data;
               state_d = ST_MEMWB;
            end
         end
         ST_MEMWB: begin
            cw_en         = 1'b1;
            cw_sel        = csel_q;
            cw_val        = data_q;
            gpr_wr_en_d   = 1'b1;
            gpr_wr_data_d = base_q + GPR_POSTINC;
            irq_block_d   = 1'b1;
            ready_d       = 1'b1;
            state_d       = ST_EXEC;
            slot_done     = pend_q;
         end
         default: begin
            state_d = ST_EXEC;
            ready_d = 1'b1;
         end
      endcase
      if (slot_done) begin
         redirect_d      = 1'b1;
         redirect_addr_d = tgt_q;
         pend_d          = 1'b0;
      end
      if (cw_en) begin
         unique case (cw_sel)
            CR_STATUS: status_d = cw_val & STATUS_MASK;
            CR_GPTR:   gptr_d   = cw_val;
            CR_VTAB:   vtab_d   = cw_val;
            CR_WRAP:   wrap_d   = cw_val;
            CR_LEND:   lend_d   = cw_val;
            CR_LBEG:   lbeg_d   = cw_val;
            default:   status_d = status_word_q;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q               <= ST_EXEC;
         insn_ready_q          <= 1'b1;
         pend_q                <= 1'b0;
         tgt_q                 <= CREG_RESET;
         base_q                <= CREG_RESET;
         data_q                <= CREG_RESET;
         csel_q                <= CR_STATUS;
         status_word_q         <= CREG_RESET;
         global_base_ptr_q     <= CREG_RESET;
         vector_table_base_q   <= CREG_RESET;
         address_wrap_bounds_q <= CREG_RESET;
         loop_end_addr_q       <= CREG_RESET;
         loop_begin_addr_q     <= CREG_RESET;
         gpr_wr_en_q           <= 1'b0;
         gpr_wr_idx_q          <= 4'h0;
         gpr_wr_data_q         <= CREG_RESET;
         link_wr_en_q          <= 1'b0;
         link_wr_data_q        <= CREG_RESET;
         mem_rd_req_q          <= 1'b0;
         mem_rd_addr_q         <= CREG_RESET;
         redirect_q            <= 1'b0;
         redirect_addr_q       <= CREG_RESET;
         illegal_slot_q        <= 1'b0;
         illegal_insn_q        <= 1'b0;
         irq_block_q           <= 1'b0;
      end else if (clk_en) begin
         state_q               <= state_d;
         insn_ready_q          <= ready_d;
         pend_q                <= pend_d;
         tgt_q                 <= tgt_d;
         base_q                <= base_d;
         data_q                <= data_d;
         csel_q                <= csel_d;
         status_word_q         <= status_d;
         global_base_ptr_q     <= gptr_d;
         vector_table_base_q   <= vtab_d;
         address_wrap_bounds_q <= wrap_d;
         loop_end_addr_q       <= lend_d;
         loop_begin_addr_q     <= lbeg_d;
         gpr_wr_en_q           <= gpr_wr_en_d;
         gpr_wr_idx_q          <= gpr_wr_idx_d;
         gpr_wr_data_q         <= gpr_wr_data_d;
         link_wr_en_q          <= link_wr_en_d;
         link_wr_data_q        <= link_wr_data_d;
         mem_rd_req_q          <= mem_rd_req_d;
         mem_rd_addr_q         <= mem_rd_addr_d;
         redirect_q            <= redirect_d;
         redirect_addr_q       <= redirect_addr_d;
         illegal_slot_q        <= illegal_slot_d;
         illegal_insn_q        <= illegal_insn_d;
         irq_block_q           <= irq_block_d;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   property p_gptr_load;
      @(posedge ref_clk) disable iff (rst)
      clk_en && take && dv.op == OP_CTL_REG && dv.creg == CR_GPTR |=> global_base_ptr_q == $past(src_gpr);
   endproperty
   a_gptr_load: assert property (p_gptr_load) else $error("global base not loaded from source");

   property p_status_mask;
      @(posedge ref_clk) disable iff (rst)
      clk_en && take && dv.op == OP_CTL_REG && dv.creg == CR_STATUS |=> status_word_q == ($past(src_gpr) & STATUS_MASK);
   endproperty
   a_status_mask: assert property (p_status_mask) else $error("status word not masked on load");

   property p_mem_req;
      @(posedge ref_clk) disable iff (rst)
      clk_en && take && dv.op == OP_CTL_MEM |=> mem_rd_req_q && mem_rd_addr_q == $past(src_gpr) && !insn_ready_q;
   endproperty
   a_mem_req: assert property (p_mem_req) else $error("memory load did not request source address");

   property p_mem_three;
      @(posedge ref_clk) disable iff (rst)
      clk_en && take && dv.op == OP_CTL_MEM ##1 (clk_en && mem_rd_valid) ##1 clk_en
         |=> gpr_wr_en_q && insn_ready_q && gpr_wr_data_q == $past(mem_rd_addr_q, 2) + GPR_POSTINC;
   endproperty
   a_mem_three: assert property (p_mem_three) else $error("memory load not done in three cycles");

   property p_irq_block;
      @(posedge ref_clk) disable iff (rst)
      clk_en && take && dv.op == OP_CTL_REG ##1 (clk_en && !take)[*2] |-> irq_block_q;
   endproperty
   a_irq_block: assert property (p_irq_block) else $error("interrupts not blocked after control load");

   property p_slot_order;
      @(posedge ref_clk) disable iff (rst)
      clk_en && take && dv.op == OP_DBRANCH && !pend_q ##1 (clk_en && take && dv.op == OP_CTL_REG)
         |=> redirect_q && redirect_addr_q == $past(src_gpr, 2);
   endproperty
   a_slot_order: assert property (p_slot_order) else $error("redirect missing or wrong after slot");

   property p_slot_branch;
      @(posedge ref_clk) disable iff (rst)
      clk_en && take && pend_q && (dv.op == OP_DBRANCH || dv.op == OP_BRANCH) |=> illegal_slot_q && !redirect_q;
   endproperty
   a_slot_branch: assert property (p_slot_branch) else $error("branch in slot not flagged");

   property p_loop_end;
      @(posedge ref_clk) disable iff (rst)
      clk_en && take && dv.op == OP_LOOP_END && !pend_q
         |=> loop_end_addr_q == $past(insn_addr) + PC_AHEAD + disp_offset($past(insn[DISP_MSB:0]));
   endproperty
   a_loop_end: assert property (p_loop_end) else $error("loop end address wrong");

   property p_loop_slot;
      @(posedge ref_clk) disable iff (rst)
      clk_en && take && dv.op == OP_LOOP_BEGIN && pend_q
         |=> loop_begin_addr_q == $past(tgt_q) + SLOT_PC_OFS + disp_offset($past(insn[DISP_MSB:0]));
   endproperty
   a_loop_slot: assert property (p_loop_slot) else $error("loop begin address in slot wrong");

   property p_no_repeat;
      @(posedge ref_clk) disable iff (rst)
      clk_en && take && !HAS_REPEAT && ((insn & MASK_HI8) == OPC_LOOP_END)
         |=> illegal_insn_q && $stable(loop_end_addr_q);
   endproperty
   a_no_repeat: assert property (p_no_repeat) else $error("loop load accepted without repeat hardware");

endmodule // ctrl_load_unit
`default_nettype wire

// >>> verif/test_ctrl_load_unit.sv
`timescale 1ns/1ns
`default_nettype none
module test_ctrl_load_unit;
   import ctrl_load_pkg::*;

   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic        ref_clk;
   logic        rst;
   logic        clk_en;
   logic        insn_valid;
   logic [15:0] insn;
   logic [31:0] insn_addr;
   logic [31:0] src_gpr;
   logic        mem_rd_valid;
   logic [31:0] mem_rd_data;
   logic        insn_ready_q, gpr_wr_en_q, link_wr_en_q, mem_rd_req_q;
   logic        redirect_q, illegal_slot_q, illegal_insn_q, irq_block_q;
   logic [31:0] status_word_q, global_base_ptr_q, vector_table_base_q, address_wrap_bounds_q;
   logic [31:0] loop_end_addr_q, loop_begin_addr_q, gpr_wr_data_q, link_wr_data_q;
   logic [31:0] mem_rd_addr_q, redirect_addr_q;
   logic [3:0]  gpr_wr_idx_q;
   logic        illegal_insn_nr;
   logic [31:0] loop_end_nr;
   int          n_mismatch;
   int          cmp_count;

   // ---------------------------------------------------------------
   // design instances
   // ---------------------------------------------------------------
   ctrl_load_unit #(.HAS_REPEAT(1'b1)) uut (
      .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .insn_valid(insn_valid), .insn(insn),
      .insn_addr(insn_addr), .src_gpr(src_gpr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
      .insn_ready_q(insn_ready_q), .status_word_q(status_word_q), .global_base_ptr_q(global_base_ptr_q),
      .vector_table_base_q(vector_table_base_q), .address_wrap_bounds_q(address_wrap_bounds_q),
      .loop_end_addr_q(loop_end_addr_q), .loop_begin_addr_q(loop_begin_addr_q),
      .gpr_wr_en_q(gpr_wr_en_q), .gpr_wr_idx_q(gpr_wr_idx_q), .gpr_wr_data_q(gpr_wr_data_q),
      .link_wr_en_q(link_wr_en_q), .link_wr_data_q(link_wr_data_q), .mem_rd_req_q(mem_rd_req_q),
      .mem_rd_addr_q(mem_rd_addr_q), .redirect_q(redirect_q), .redirect_addr_q(redirect_addr_q),
      .illegal_slot_q(illegal_slot_q), .illegal_insn_q(illegal_insn_q), .irq_block_q(irq_block_q));

   // core variant without repeat hardware, fed the same stream
   ctrl_load_unit #(.HAS_REPEAT(1'b0)) uut_norep (
      .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .insn_valid(insn_valid), .insn(insn),
      .insn_addr(insn_addr), .src_gpr(src_gpr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
      .insn_ready_q(), .status_word_q(), .global_base_ptr_q(), .vector_table_base_q(),
      .address_wrap_bounds_q(), .loop_end_addr_q(loop_end_nr), .loop_begin_addr_q(), .gpr_wr_en_q(),
      .gpr_wr_idx_q(), .gpr_wr_data_q(), .link_wr_en_q(), .link_wr_data_q(), .mem_rd_req_q(),
      .mem_rd_addr_q(), .redirect_q(), .redirect_addr_q(), .illegal_slot_q(), .illegal_insn_q(illegal_insn_nr),
      .irq_block_q());

   always #2 ref_clk = ~ref_clk;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // called at a falling edge; returns at the falling edge after the taking edge
   task automatic offer(input logic [15:0] op, input logic [31:0] addr, input logic [31:0] src);
      insn       = op;
      insn_addr  = addr;
      src_gpr    = src;
      insn_valid = 1'b1;
      @(negedge ref_clk);
   endtask

   task automatic idle();
      insn_valid = 1'b0;
      src_gpr    = ~src_gpr;
      @(negedge ref_clk);
   endtask

   task automatic wrap_up();
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reg_loads();
      offer(16'h410e, 32'h0, 32'hffffffff);
      chk(status_word_q, 32'h0fff0fff);
      chk(irq_block_q, 1'b1);
      // clock enable low: the offer must leave every register frozen
      clk_en = 1'b0;
      offer(16'h411e, 32'h0, 32'h5555_5555);
      chk(global_base_ptr_q, 32'h0);
      chk(irq_block_q, 1'b1);
      clk_en = 1'b1;
      offer(16'h411e, 32'h0, 32'h12345678);
      chk(global_base_ptr_q, 32'h12345678);
      offer(16'h412e, 32'h0, 32'h8000_0400);
      chk(vector_table_base_q, 32'h8000_0400);
      offer(16'h415e, 32'h0, 32'h00f0_0010);
      chk(address_wrap_bounds_q, 32'h00f0_0010);
      offer(16'h417e, 32'h0, 32'h0000_2222);
      chk(loop_end_addr_q, 32'h0000_2222);
      offer(16'h416e, 32'h0, 32'h0000_1110);
      chk(loop_begin_addr_q, 32'h0000_1110);
      chk(global_base_ptr_q, 32'h12345678);
      offer(16'h410e, 32'h0, 32'h0000_0001);
      chk(status_word_q, 32'h0000_0001);
      offer(16'h0009, 32'h0, 32'h0);
      chk(irq_block_q, 1'b0);
      idle();
   endtask

   task automatic t_mem(input logic [15:0] op, input logic [31:0] a, input logic [31:0] d, input logic is_sr);
      offer(op, 32'h0, a);
      insn_valid = 1'b0;
      chk(mem_rd_req_q, 1'b1);
      chk(mem_rd_addr_q, a);
      chk(insn_ready_q, 1'b0);
      mem_rd_valid = 1'b1;
      mem_rd_data  = d;
      @(negedge ref_clk);
      mem_rd_valid = 1'b0;
      mem_rd_data  = ~d;
      @(negedge ref_clk);
      chk(gpr_wr_en_q, 1'b1);
      chk(gpr_wr_idx_q, op[11:8]);
      chk(gpr_wr_data_q, a + 32'h4);
      chk(insn_ready_q, 1'b1);
      chk(irq_block_q, 1'b1);
      chk(is_sr ? status_word_q : global_base_ptr_q, is_sr ? (d & 32'h0fff0fff) : d);
      @(negedge ref_clk);
   endtask

   task automatic t_loop();
      offer(16'h8e7f, 32'h0000_1000, 32'h0);
      chk(loop_end_addr_q, 32'h0000_1102);
      chk(illegal_insn_nr, 1'b1);
      offer(16'h8c80, 32'h0000_1000, 32'h0);
      chk(loop_begin_addr_q, 32'h0000_0f04);
      chk(illegal_insn_q, 1'b0);
      chk(illegal_insn_nr, 1'b1);
      chk(loop_end_nr, 32'h0000_2222);
      idle();
   endtask

   task automatic t_branch();
      offer(16'h420b, 32'h0000_0100, 32'h0000_2000);
      chk(redirect_q, 1'b0);
      chk(link_wr_en_q, 1'b1);
      chk(link_wr_data_q, 32'h0000_0104);
      offer(16'h8c02, 32'h0000_0102, 32'h0000_9998);
      chk(redirect_q, 1'b1);
      chk(redirect_addr_q, 32'h0000_2000);
      chk(loop_begin_addr_q, 32'h0000_2006);
      idle();
      chk(redirect_q, 1'b0);
   endtask

   task automatic t_slot_branch();
      offer(16'h432b, 32'h0000_0200, 32'h0000_3000);
      offer(16'ha010, 32'h0000_0202, 32'h0);
      chk(illegal_slot_q, 1'b1);
      chk(redirect_q, 1'b0);
      idle();
      chk(redirect_q, 1'b0);
      chk(illegal_slot_q, 1'b0);
   endtask

   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      ref_clk      = 1'b0;
      rst          = 1'b1;
      clk_en       = 1'b1;
      insn_valid   = 1'b0;
      insn         = 16'h0000;
      insn_addr    = 32'h0;
      src_gpr      = 32'h0;
      mem_rd_valid = 1'b0;
      mem_rd_data  = 32'h0;
      n_mismatch   = 0;
      cmp_count    = 0;
      repeat (6) @(negedge ref_clk);
      rst = 1'b0;
      chk(insn_ready_q, 1'b1);
      chk(status_word_q, 32'h0);
      t_reg_loads();
      t_mem(16'h4307, 32'h1000_0000, 32'hffff_ffff, 1'b1);
      t_mem(16'h4517, 32'h1000_0010, 32'hcafe_0123, 1'b0);
      t_loop();
      t_branch();
      t_slot_branch();
      wrap_up();
   end

   initial begin
      #8000;
      n_mismatch++;
      wrap_up();
   end

endmodule // test_ctrl_load_unit
`default_nettype wire
